//--- wpf_magic_det.sv
package wpf_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_FILTER_CTRL = 12'h000;
  localparam logic [11:0] OFF_CAUSE = 12'h004;
  localparam logic [11:0] OFF_PM_CTRL = 12'h008;
  localparam logic [11:0] OFF_RX_CTRL = 12'h00C;
  localparam logic [11:0] OFF_LINK = 12'h010;
  localparam logic [11:0] OFF_RA_BASE = 12'h040;
  localparam logic [11:0] OFF_IP4_BASE = 12'h0C0;
  localparam logic [11:0] OFF_IP4_END = 12'h0D0;
  localparam logic [11:0] OFF_STORE_BASE = 12'h100;
  localparam logic [11:0] OFF_STORE_END = 12'h180;
  localparam logic [11:0] OFF_MTA_BASE = 12'h200;
  localparam logic [11:0] OFF_MTA_END = 12'h400;
  // field positions
  localparam int BIT_LNK = 0;
  localparam int BIT_EX = 1;
  localparam int BIT_MC = 2;
  localparam int BIT_BC = 3;
  localparam int BIT_MAG = 4;
  localparam int BIT_ARP = 5;
  localparam int CAUSE_W = 6;
  localparam logic [5:0] CAUSE_PKT = 6'h3E;
  localparam int BIT_PM_EN = 8;
  localparam int BIT_PM_FLAG = 15;
  localparam int BIT_BAM = 15;
  localparam int MO_LSB = 12;
  localparam int BIT_RA_VALID = 31;
  // table sizes
  localparam int RA_ENTRIES = 16;
  localparam int IP4_ENTRIES = 4;
  localparam int MTA_WORDS = 128;
  localparam int STORE_WORDS = 32;
  // frame layout
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [2:0] SYNC_RUN = 3'h6;
  localparam logic [2:0] ADDR_LAST = 3'h5;
  localparam logic [6:0] COPY_LAST = 7'h5F;
  localparam logic [15:0] DEST_BYTES = 16'h0006;
  localparam logic [15:0] STORE_BYTES = 16'h0080;
  localparam logic [15:0] OFS_TYPE_HI = 16'h000C;
  localparam logic [15:0] OFS_TYPE_LO = 16'h000D;
  localparam logic [15:0] OFS_ARP_FIRST = 16'h000E;
  localparam logic [15:0] OFS_ARP_LAST = 16'h0015;
  localparam logic [15:0] OFS_TPA_FIRST = 16'h0026;
  localparam logic [15:0] OFS_TPA_LAST = 16'h0029;
  localparam logic [3:0] VLAN_LEN = 4'h4;
  localparam logic [3:0] SNAP_LEN = 4'h8;
  localparam logic [15:0] TYPE_VLAN = 16'h8100;
  localparam logic [15:0] TYPE_MIN = 16'h0600;
  localparam logic [15:0] TYPE_ARP = 16'h0806;
  localparam logic [63:0] ARP_HDR = 64'h0001_0800_0604_0001;
  localparam logic [47:0] BCAST_ADDR = 48'hFFFF_FFFF_FFFF;
endpackage

`timescale 1ns/1ns
module wpf_magic_det (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // receive byte stream
  input wire logic rxValid,
  input wire logic rxSof,
  input wire logic [7:0] rxData,
  // station address, first byte in [7:0]
  input wire logic [47:0] stationAddr,
  // result, held until next frame start
  output logic found
);
  typedef struct packed {
    logic [2:0] ffCnt;
    logic copying;
    logic [2:0] byteIdx;
    logic [6:0] copyCnt;
    logic found;
  } wpf_magic_t;

  wpf_magic_t st_r;
  wpf_magic_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (rxValid) begin
      if (rxSof) begin
        st_nxt = '0;
      end
      if (st_nxt.copying) begin
        if (rxData == stationAddr[{st_nxt.byteIdx, 3'b000} +: 8]) begin
          if (st_nxt.copyCnt == wpf_pkg::COPY_LAST) begin
            st_nxt.found = 1'b1; // RQ17
            st_nxt.copying = 1'b0;
            st_nxt.ffCnt = 3'h0;
          end
          st_nxt.copyCnt = st_nxt.copyCnt + 7'h01;
          st_nxt.byteIdx = (st_nxt.byteIdx == wpf_pkg::ADDR_LAST) ? 3'h0 : st_nxt.byteIdx + 3'h1;
        end else begin
          // a mismatching byte may itself open a new run
          st_nxt.copying = 1'b0; // RQ19
          st_nxt.ffCnt = (rxData == wpf_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
        end
      end else if (rxData == wpf_pkg::SYNC_BYTE) begin
        if (st_nxt.ffCnt != wpf_pkg::SYNC_RUN) begin
          st_nxt.ffCnt = st_nxt.ffCnt + 3'h1; // RQ18
        end
      end else if (st_nxt.ffCnt == wpf_pkg::SYNC_RUN &&
                   rxData == stationAddr[7:0]) begin
        st_nxt.copying = 1'b1; // RQ18
        st_nxt.copyCnt = 7'h01;
        st_nxt.byteIdx = 3'h1;
      end else begin
        st_nxt.ffCnt = 3'h0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign found = st_r.found;
endmodule

//--- wpf_frame_parse.sv
`timescale 1ns/1ns
module wpf_frame_parse (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // receive byte stream
  input wire logic rxValid,
  input wire logic rxSof,
  input wire logic [7:0] rxData,
  // parsed fields, held until next frame start
  output logic [15:0] byteCnt,
  output logic [47:0] destAddr,
  output logic arpHit,
  output logic [31:0] targetIp
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [3:0] shift;
    logic [7:0] typeHi;
    logic typeDone;
    logic vlan;
    logic snap;
    logic arpOk;
    logic arpEnd;
    logic [47:0] dest;
    logic [31:0] tpa;
  } wpf_parse_t;

  wpf_parse_t st_r;
  wpf_parse_t st_nxt;
  logic [15:0] rel;
  logic [2:0] hdrIdx;
  logic [15:0] etype;

  always_comb begin
    st_nxt = st_r;
    rel = '0;
    hdrIdx = '0;
    etype = '0;
    if (rxValid) begin
      if (rxSof) begin
        st_nxt = '0;
      end
      // offsets beyond the type field slide with each optional header
      rel = st_nxt.cnt - 16'(st_nxt.shift); // RQ13
      if (st_nxt.cnt < wpf_pkg::DEST_BYTES) begin
        st_nxt.dest[{st_nxt.cnt[2:0], 3'b000} +: 8] = rxData;
      end
      if (!st_nxt.typeDone) begin
        etype = {st_nxt.typeHi, rxData};
        if (rel == wpf_pkg::OFS_TYPE_HI) begin
          st_nxt.typeHi = rxData;
        end else if (rel == wpf_pkg::OFS_TYPE_LO) begin
          if (etype == wpf_pkg::TYPE_VLAN && !st_nxt.vlan && !st_nxt.snap) begin
            st_nxt.vlan = 1'b1; // RQ13
            st_nxt.shift = st_nxt.shift + wpf_pkg::VLAN_LEN;
          end else if (etype < wpf_pkg::TYPE_MIN && !st_nxt.snap) begin
            st_nxt.snap = 1'b1; // RQ13
            st_nxt.shift = st_nxt.shift + wpf_pkg::SNAP_LEN;
          end else begin
            st_nxt.typeDone = 1'b1;
            st_nxt.arpOk = (etype == wpf_pkg::TYPE_ARP); // RQ21
          end
        end
      end else if (rel >= wpf_pkg::OFS_ARP_FIRST && rel <= wpf_pkg::OFS_ARP_LAST) begin
        hdrIdx = 3'h7 - rel[2:0] + 3'h6;
        if (rxData != wpf_pkg::ARP_HDR[{hdrIdx, 3'b000} +: 8]) begin
          st_nxt.arpOk = 1'b0; // RQ21
        end
      end else if (rel >= wpf_pkg::OFS_TPA_FIRST && rel <= wpf_pkg::OFS_TPA_LAST) begin
        hdrIdx = rel[2:0] - 3'h6;
        st_nxt.tpa[{hdrIdx[1:0], 3'b000} +: 8] = rxData; // RQ22
        st_nxt.arpEnd = (rel == wpf_pkg::OFS_TPA_LAST);
      end
      if (st_nxt.cnt != 16'hFFFF) begin
        st_nxt.cnt = st_nxt.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign byteCnt = st_r.cnt;
  assign destAddr = st_r.dest;
  assign arpHit = st_r.arpOk & st_r.arpEnd;
  assign targetIp = st_r.tpa;
endmodule

//--- wpf_wake_filter.sv
// Contract
// RQ1: wake comes from repeated-address frame, filter-matched frame or link change.
// RQ2: host sets event-enable bit 8 after programming filters and tables.
// RQ3: host then writes 11b to the power-state bits.
// RQ4: wake needs enable, address filter pass and one enabled wake filter hit.
// RQ5: qualifying frame sets the event flag.
// RQ6: qualifying frame drives wake pin low only with event-enable set.
// RQ7: qualifying frame leaves its first 128 bytes in the frame store.
// RQ8: every enabled filter that matched sets its own cause bit.
// RQ9: enabled link change sets flag, link-changed bit and drives the pin.
// RQ10: pin stays low until flag cleared by one or enable written zero.
// RQ11: frames ignored while packet causes set; link ignored while link bit set.
// RQ12: each wake filter works only while its enable bit is one.
// RQ13: optional VLAN tag and LLC/SNAP header shift later field offsets.
// RQ14: exact wake on destination equal to any of 16 valid addresses.
// RQ15: multicast wake uses offset-selected address bits to index table.
// RQ16: broadcast wake on all-ones destination.
// RQ17: repeated-address search finds sync run then 16 station address copies.
// RQ18: first non-FF byte after six or more FF starts the copies.
// RQ19: mismatch inside the 96 bytes restarts the search later.
// RQ20: repeated-address frames accept broadcast even with broadcast accept clear.
// RQ21: ARP wake checks broadcast, type, hardware/protocol type, sizes, opcode.
// RQ22: ARP target address compared against all four IPv4 entries.
// RQ23: status, flag and store commit only on good-CRC frame end.
`timescale 1ns/1ns
module wpf_wake_filter (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive frames after the mac
  input wire logic rxValid,
  input wire logic rxSof,
  input wire logic rxEof,
  input wire logic [7:0] rxData,
  input wire logic rxCrcOk,
  // link status pin
  input wire logic linkUpPin,
  // wake pin to host
  output logic hostWakePinN
);
  typedef struct packed {
    logic [wpf_pkg::CAUSE_W-1:0] filterCtrl;
    logic [wpf_pkg::CAUSE_W-1:0] cause;
    logic [1:0] pmState;
    logic pmEn;
    logic pmFlag;
    logic [1:0] mo;
    logic bam;
    logic [wpf_pkg::RA_ENTRIES-1:0][47:0] raAddr;
    logic [wpf_pkg::RA_ENTRIES-1:0] raValid;
    logic [wpf_pkg::IP4_ENTRIES-1:0][31:0] ip4;
    logic [wpf_pkg::MTA_WORDS-1:0][31:0] mta;
    logic [wpf_pkg::STORE_WORDS-1:0][31:0] store;
    logic [2:0] linkSync;
    logic linkState;
    logic commitPend;
    logic commitCrc;
    logic wakeOn;
    logic [31:0] rdata;
  } wpf_state_t;

  wpf_state_t st_r;
  wpf_state_t st_nxt;

  logic [15:0] byteCnt;
  logic [47:0] destAddr;
  logic arpHit;
  logic [31:0] targetIp;
  logic magicFound;
  logic isRa;
  logic isIp4;
  logic isStore;
  logic isMta;
  logic mapped;
  logic [31:0] readWord;
  logic [31:0] strbMask;
  logic [11:0] hashIdx;
  logic bcast;
  logic mcast;
  logic exactHit;
  logic mtaHit;
  logic ipHit;
  logic addrPass;
  logic [wpf_pkg::CAUSE_W-1:0] matchVec;
  logic [wpf_pkg::CAUSE_W-1:0] hits;
  logic frameHit;
  logic [15:0] byteIdx;
  logic [3:0] raIdx;

  wpf_frame_parse uParse (
    .core_clk(core_clk),
    .rst(rst),
    .rxValid(rxValid),
    .rxSof(rxSof),
    .rxData(rxData),
    .byteCnt(byteCnt),
    .destAddr(destAddr),
    .arpHit(arpHit),
    .targetIp(targetIp)
  );

  wpf_magic_det uMagic (
    .core_clk(core_clk),
    .rst(rst),
    .rxValid(rxValid),
    .rxSof(rxSof),
    .rxData(rxData),
    .stationAddr(st_r.raAddr[0]),
    .found(magicFound)
  );

  function automatic logic [11:0] mtaIndex(input logic [47:0] a, input logic [1:0] sel);
    logic [11:0] r;
    unique case (sel)
      2'h0: r = a[47:36];
      2'h1: r = a[46:35];
      2'h2: r = a[45:34];
      2'h3: r = a[43:32];
    endcase
    return r;
  endfunction

  // address decode
  assign isRa = paddr >= wpf_pkg::OFF_RA_BASE && paddr < wpf_pkg::OFF_IP4_BASE;
  assign isIp4 = paddr >= wpf_pkg::OFF_IP4_BASE && paddr < wpf_pkg::OFF_IP4_END;
  assign isStore = paddr >= wpf_pkg::OFF_STORE_BASE && paddr < wpf_pkg::OFF_STORE_END;
  assign isMta = paddr >= wpf_pkg::OFF_MTA_BASE && paddr < wpf_pkg::OFF_MTA_END;
  assign mapped = isRa | isIp4 | isStore | isMta | paddr == wpf_pkg::OFF_FILTER_CTRL |
                  paddr == wpf_pkg::OFF_CAUSE | paddr == wpf_pkg::OFF_PM_CTRL |
                  paddr == wpf_pkg::OFF_RX_CTRL | paddr == wpf_pkg::OFF_LINK;
  assign strbMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  // table base has bit 6 set, so entry 0 must not land on index 8
  assign raIdx = {~paddr[6], paddr[5:3]};

  always_comb begin
    readWord = '0;
    if (paddr == wpf_pkg::OFF_FILTER_CTRL) begin
      readWord = 32'(st_r.filterCtrl);
    end else if (paddr == wpf_pkg::OFF_CAUSE) begin
      readWord = 32'(st_r.cause);
    end else if (paddr == wpf_pkg::OFF_PM_CTRL) begin
      readWord[wpf_pkg::BIT_PM_FLAG] = st_r.pmFlag;
      readWord[wpf_pkg::BIT_PM_EN] = st_r.pmEn;
      readWord[1:0] = st_r.pmState;
    end else if (paddr == wpf_pkg::OFF_RX_CTRL) begin
      readWord[wpf_pkg::BIT_BAM] = st_r.bam;
      readWord[wpf_pkg::MO_LSB +: 2] = st_r.mo;
    end else if (paddr == wpf_pkg::OFF_LINK) begin
      readWord[0] = st_r.linkState;
    end else if (isRa) begin
      if (paddr[2]) begin
        readWord[15:0] = st_r.raAddr[raIdx][47:32];
        readWord[wpf_pkg::BIT_RA_VALID] = st_r.raValid[raIdx];
      end else begin
        readWord = st_r.raAddr[raIdx][31:0];
      end
    end else if (isIp4) begin
      readWord = st_r.ip4[paddr[3:2]];
    end else if (isStore) begin
      readWord = st_r.store[paddr[6:2]];
    end else if (isMta) begin
      readWord = st_r.mta[paddr[8:2]];
    end
  end

  // frame classification, valid in the cycle after the last byte
  always_comb begin
    exactHit = 1'b0;
    for (int i = 0; i < wpf_pkg::RA_ENTRIES; i++) begin
      if (st_r.raValid[i] && st_r.raAddr[i] == destAddr) begin
        exactHit = 1'b1; // RQ14
      end
    end
    ipHit = 1'b0;
    for (int i = 0; i < wpf_pkg::IP4_ENTRIES; i++) begin
      if (st_r.ip4[i] == targetIp) begin
        ipHit = 1'b1; // RQ22
      end
    end
  end

  assign hashIdx = mtaIndex(destAddr, st_r.mo); // RQ15
  assign mtaHit = st_r.mta[hashIdx[11:5]][hashIdx[4:0]]; // RQ15
  assign bcast = destAddr == wpf_pkg::BCAST_ADDR; // RQ16
  assign mcast = destAddr[0] & ~bcast;
  assign addrPass = exactHit | (mcast & mtaHit) | (bcast & st_r.bam); // RQ4
  always_comb begin
    matchVec = '0;
    matchVec[wpf_pkg::BIT_EX] = exactHit & addrPass;
    matchVec[wpf_pkg::BIT_MC] = mcast & mtaHit & addrPass; // RQ15
    matchVec[wpf_pkg::BIT_BC] = bcast & addrPass; // RQ16
    // broadcast accept is waived for the repeated-address case only
    matchVec[wpf_pkg::BIT_MAG] = magicFound & (addrPass | bcast); // RQ20
    matchVec[wpf_pkg::BIT_ARP] = arpHit & bcast & ipHit & addrPass; // RQ21
  end
  assign hits = matchVec & st_r.filterCtrl & wpf_pkg::CAUSE_PKT; // RQ12
  assign frameHit = st_r.commitPend & st_r.commitCrc & st_r.pmEn & (|hits); // RQ23
  assign byteIdx = rxSof ? 16'h0000 : byteCnt;

  always_comb begin
    st_nxt = st_r;
    // register writes take effect at the access edge
    if (psel && penable && pwrite) begin
      if (paddr == wpf_pkg::OFF_FILTER_CTRL) begin
        st_nxt.filterCtrl = (st_r.filterCtrl & ~strbMask[5:0]) | (pwdata[5:0] & strbMask[5:0]);
      end else if (paddr == wpf_pkg::OFF_CAUSE) begin
        st_nxt.cause = st_r.cause & ~(pwdata[5:0] & strbMask[5:0]);
      end else if (paddr == wpf_pkg::OFF_PM_CTRL) begin
        if (pstrb[0]) begin
          st_nxt.pmState = pwdata[1:0];
        end
        if (pstrb[1]) begin
          st_nxt.pmEn = pwdata[wpf_pkg::BIT_PM_EN];
          st_nxt.pmFlag = st_r.pmFlag & ~pwdata[wpf_pkg::BIT_PM_FLAG]; // RQ10
        end
      end else if (paddr == wpf_pkg::OFF_RX_CTRL) begin
        if (pstrb[1]) begin
          st_nxt.bam = pwdata[wpf_pkg::BIT_BAM];
          st_nxt.mo = pwdata[wpf_pkg::MO_LSB +: 2];
        end
      end else if (isRa) begin
        if (paddr[2]) begin
          st_nxt.raAddr[raIdx][47:32] =
            (st_r.raAddr[raIdx][47:32] & ~strbMask[15:0]) | (pwdata[15:0] & strbMask[15:0]);
          if (pstrb[3]) begin
            st_nxt.raValid[raIdx] = pwdata[wpf_pkg::BIT_RA_VALID];
          end
        end else begin
          st_nxt.raAddr[raIdx][31:0] =
            (st_r.raAddr[raIdx][31:0] & ~strbMask) | (pwdata & strbMask);
        end
      end else if (isIp4) begin
        st_nxt.ip4[paddr[3:2]] = (st_r.ip4[paddr[3:2]] & ~strbMask) | (pwdata & strbMask);
      end else if (isMta) begin
        st_nxt.mta[paddr[8:2]] = (st_r.mta[paddr[8:2]] & ~strbMask) | (pwdata & strbMask);
      end
    end
    // read data captured in the setup cycle
    if (psel && !penable) begin
      st_nxt.rdata = readWord;
    end
    // link status: three stages, change taken once the last two agree
    st_nxt.linkSync = {st_r.linkSync[1:0], linkUpPin};
    if (st_r.linkSync[2] == st_r.linkSync[1] && st_r.linkSync[2] != st_r.linkState) begin
      st_nxt.linkState = st_r.linkSync[2];
      if (st_r.filterCtrl[wpf_pkg::BIT_LNK] && !st_nxt.cause[wpf_pkg::BIT_LNK]) begin // RQ11
        st_nxt.cause[wpf_pkg::BIT_LNK] = 1'b1; // RQ9
        st_nxt.pmFlag = 1'b1; // RQ9
      end
    end
    // frame commit; sets are applied after clears so the set wins
    st_nxt.commitPend = rxValid & rxEof;
    st_nxt.commitCrc = rxCrcOk;
    if (frameHit && (st_nxt.cause & wpf_pkg::CAUSE_PKT) == '0) begin // RQ11
      st_nxt.cause = st_nxt.cause | hits; // RQ8
      st_nxt.pmFlag = 1'b1; // RQ5
    end
    // store fills live; frozen once a frame has claimed it
    if (rxValid && byteIdx < wpf_pkg::STORE_BYTES &&
        (st_r.cause & wpf_pkg::CAUSE_PKT) == '0 && !frameHit) begin
      st_nxt.store[byteIdx[6:2]][{byteIdx[1:0], 3'b000} +: 8] = rxData; // RQ7
    end
    st_nxt.wakeOn = st_nxt.pmFlag & st_nxt.pmEn; // RQ1 RQ6
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign hostWakePinN = ~st_r.wakeOn; // RQ10
endmodule

//--- wpf_wake_filter_assertions.sv
`timescale 1ns/1ns
module wpf_wake_filter_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // receive stream and pins
  input wire logic rxValid,
  input wire logic rxSof,
  input wire logic rxEof,
  input wire logic [7:0] rxData,
  input wire logic rxCrcOk,
  input wire logic linkUpPin,
  input wire logic hostWakePinN
);
  // cycles since the link pin moved, saturating
  logic [3:0] linkAge_r;
  logic linkPrev_r;
  logic pmWr;
  assign pmWr = psel && penable && pwrite && paddr[11:2] == 10'h002;
  always_ff @(posedge core_clk) begin
    linkPrev_r <= linkUpPin;
    if (rst || linkUpPin != linkPrev_r) begin
      linkAge_r <= 4'h0;
    end else if (linkAge_r != 4'hF) begin
      linkAge_r <= linkAge_r + 4'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_pin_reset: assert property ($fell(rst) |-> hostWakePinN)
    else $error("wake pin low after reset");
  chk_pin_held: assert property (!hostWakePinN && !pmWr |=> !hostWakePinN)
    else $error("wake pin released without host write");
  chk_pin_enoff: assert property (pmWr && pstrb[1] && !pwdata[8] |=> hostWakePinN)
    else $error("wake pin stays low with enable off");
  chk_pin_ack: assert property (pmWr && pstrb[1] && pwdata[15] && !$past(rxValid)
    && linkAge_r == 4'hF |=> hostWakePinN)
    else $error("wake pin stays low after flag clear");
  chk_pin_cause: assert property ($fell(hostWakePinN) |-> $past(rxValid && rxEof && rxCrcOk, 2)
    || linkAge_r < 4'h8 || $past(pmWr))
    else $error("wake pin fell without a cause");
  chk_bad_crc: assert property (rxValid && rxEof && !rxCrcOk && hostWakePinN && !pmWr
    && linkAge_r == 4'hF |=> hostWakePinN [*2])
    else $error("bad frame raised wake");
  chk_bus_ready: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  chk_err_unmapped: assert property (psel && penable && paddr[11:2] == 10'h005 |-> pslverr)
    else $error("unmapped access without error");
  chk_err_mapped: assert property (psel && penable && paddr[11:2] < 10'h005 |-> !pslverr)
    else $error("mapped access flagged error");
  chk_err_setup: assert property (psel && !penable |-> !pslverr)
    else $error("error in setup cycle");
  cover property ($fell(hostWakePinN));
  cover property (pslverr);
  cover property (rxValid && rxEof && !rxCrcOk);
endmodule

bind wpf_wake_filter wpf_wake_filter_chk u_chk (
  .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof), .rxData(rxData),
  .rxCrcOk(rxCrcOk), .linkUpPin(linkUpPin), .hostWakePinN(hostWakePinN)
);

//--- wpf_host_model.sv
`timescale 1ns/1ns
module wpf_host_model (
  // clock
  input wire logic core_clk,
  // apb master
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end
  // request held until ready is seen at an edge; no wait count assumed
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // enable only after filters and tables are set
  task automatic enableWake();
    logic [31:0] rd;
    logic err;
    xfer(1'h1, wpf_pkg::OFF_PM_CTRL, 32'h0000_0100, rd, err);
    xfer(1'h1, wpf_pkg::OFF_PM_CTRL, 32'h0000_0103, rd, err);
  endtask
  // clear the flag, keep enable and low-power state
  task automatic ackWake();
    logic [31:0] rd;
    logic err;
    xfer(1'h1, wpf_pkg::OFF_PM_CTRL, 32'h0000_8103, rd, err);
  endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); \
  end \
end
module tb_top;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic rxValid = 1'h0;
  logic rxSof = 1'h0;
  logic rxEof = 1'h0;
  logic rxCrcOk = 1'h0;
  logic linkUpPin = 1'h0;
  logic [7:0] rxData = 8'h00;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hostWakePinN;
  logic [31:0] seed = 32'h0000_004B;
  int miscompares = 0;
  int checks_done = 0;
  logic [7:0] fr[$];
  logic [7:0] kept[$];
  logic [47:0] sta;
  logic [47:0] ex5;
  logic [47:0] mca;
  logic [31:0] ip;
  logic [31:0] rd;
  logic err;

  always #2 core_clk = ~core_clk;

  wpf_wake_filter dut (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof),
    .rxData(rxData), .rxCrcOk(rxCrcOk), .linkUpPin(linkUpPin), .hostWakePinN(hostWakePinN));
  wpf_host_model host (.core_clk(core_clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [47:0] rnd48();
    logic [63:0] t;
    t = {rnd(), rnd()};
    return t[47:0];
  endfunction
  function automatic logic [31:0] word(input int k);
    return {kept[4*k+3], kept[4*k+2], kept[4*k+1], kept[4*k]};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'h1, a, d, rd, err);
  endtask
  task automatic rdx(input logic [11:0] a);
    host.xfer(1'h0, a, 32'h0000_0000, rd, err);
  endtask
  // address bytes, first wire byte in the low lane
  task automatic push(input logic [47:0] a);
    for (int i = 0; i < 6; i++) fr.push_back(a[8*i+:8]);
  endtask
  // n bytes, most significant first
  task automatic put(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) fr.push_back(v[8*i+:8]);
  endtask
  task automatic start(input logic [47:0] da);
    fr.delete();
    push(da);
    push(rnd48());
  endtask
  // pad stays below 0x80 so it never forms a sync run
  task automatic send(input logic ok);
    logic [31:0] t;
    while (fr.size() < 130) begin
      t = rnd();
      fr.push_back(t[7:0] & 8'h7F);
    end
    foreach (fr[i]) begin
      @(posedge core_clk);
      rxValid <= 1'h1;
      rxSof <= (i == 0);
      rxEof <= (i == fr.size() - 1);
      rxCrcOk <= ok;
      rxData <= fr[i];
    end
    @(posedge core_clk);
    rxValid <= 1'h0;
    rxSof <= 1'h0;
    rxEof <= 1'h0;
    rxData <= ~rxData;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic chkWake(input logic [5:0] cause, input logic low);
    `CHK(hostWakePinN, ~low)
    rdx(wpf_pkg::OFF_CAUSE);
    `CHK(rd[5:0], cause)
    rdx(wpf_pkg::OFF_PM_CTRL);
    `CHK(rd[15], |cause)
    `CHK(rd[8:0], 9'h103)
  endtask
  task automatic clear();
    host.ackWake();
    @(posedge core_clk);
    #1;
    `CHK(hostWakePinN, 1'h1)
    wr(wpf_pkg::OFF_CAUSE, 32'h0000_003F);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    for (int i = 0; i < 5; i++) begin
      rdx(12'(4 * i));
      `CHK(rd, 32'h0000_0000)
    end
    rdx(12'h014);
    `CHK(err, 1'h1)
    sta = rnd48() & 48'hFFFF_FFFF_FFFE;
    ex5 = rnd48() & 48'hFFFF_FFFF_FFFE;
    mca = rnd48() | 48'h0000_0000_0001;
    ip = rnd();
    wr(wpf_pkg::OFF_RA_BASE, sta[31:0]);
    wr(wpf_pkg::OFF_RA_BASE + 12'h004, {16'h8000, sta[47:32]});
    wr(wpf_pkg::OFF_RA_BASE + 12'h028, ex5[31:0]);
    wr(wpf_pkg::OFF_RA_BASE + 12'h02C, {16'h8000, ex5[47:32]});
    wr(wpf_pkg::OFF_IP4_BASE + 12'h008, ip);
    wr(wpf_pkg::OFF_MTA_BASE + {3'h0, mca[47:41], 2'h0}, 32'h0000_0001 << mca[40:36]);
    wr(wpf_pkg::OFF_FILTER_CTRL, 32'h0000_0008);
    wr(wpf_pkg::OFF_RX_CTRL, 32'h0000_8000);
    host.enableWake();
    start(wpf_pkg::BCAST_ADDR);
    send(1'h0);
    chkWake(6'h00, 1'h0);
    start(ex5);
    send(1'h1);
    chkWake(6'h00, 1'h0);
    start(wpf_pkg::BCAST_ADDR);
    send(1'h1);
    chkWake(6'h08, 1'h1);
    kept = fr;
    for (int k = 0; k < 32; k++) begin
      rdx(wpf_pkg::OFF_STORE_BASE + 12'(4 * k));
      `CHK(rd, word(k))
    end
    // locked: a second hit must change nothing
    wr(wpf_pkg::OFF_FILTER_CTRL, 32'h0000_000A);
    start(ex5);
    send(1'h1);
    chkWake(6'h08, 1'h1);
    rdx(wpf_pkg::OFF_STORE_BASE + 12'h004);
    `CHK(rd, word(1))
    clear();
    // request behind a vlan tag, two filters hit
    wr(wpf_pkg::OFF_FILTER_CTRL, 32'h0000_0028);
    start(wpf_pkg::BCAST_ADDR);
    put(64'h8100_0005_0806_0001, 8);
    put(64'h0000_0800_0604_0001, 6);
    repeat (16) put(64'(rnd()) & 64'h0000_0000_0000_007F, 1);
    for (int i = 0; i < 4; i++) fr.push_back(ip[8*i+:8]);
    send(1'h1);
    chkWake(6'h28, 1'h1);
    clear();
    wr(wpf_pkg::OFF_FILTER_CTRL, 32'h0000_0006);
    start(ex5);
    send(1'h1);
    chkWake(6'h02, 1'h1);
    clear();
    start(mca);
    send(1'h1);
    chkWake(6'h04, 1'h1);
    clear();
    // broadcast with accept off; false start before the real run
    wr(wpf_pkg::OFF_RX_CTRL, 32'h0000_0000);
    wr(wpf_pkg::OFF_FILTER_CTRL, 32'h0000_0010);
    start(wpf_pkg::BCAST_ADDR);
    put(64'h00FF_FFFF_FFFF_FFFF, 7);
    repeat (5) push(sta);
    fr.push_back(sta[7:0] ^ 8'h01);
    put(64'h0000_FFFF_FFFF_FFFF, 6);
    repeat (16) push(sta);
    send(1'h1);
    chkWake(6'h10, 1'h1);
    clear();
    wr(wpf_pkg::OFF_FILTER_CTRL, 32'h0000_0001);
    linkUpPin <= 1'h1;
    repeat (8) @(posedge core_clk);
    #1;
    chkWake(6'h01, 1'h1);
    wr(wpf_pkg::OFF_PM_CTRL, 32'h0000_0003);
    @(posedge core_clk);
    #1;
    `CHK(hostWakePinN, 1'h1)
    summarize();
  end

  // nearly forty times the expected run
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
endmodule
